// ===== inc/trig_bus_cfg.svh
// constants for the trigger bus routing block and its far end
`ifndef TRIG_BUS_CFG_SVH
`define TRIG_BUS_CFG_SVH

// ----------------------------------------------------------------
// bus shape
// ----------------------------------------------------------------
`define TB_NLINES       7
`define TB_CLK_LINE     7
`define TB_ADDR_W       8
`define TB_DATA_W       32

// ----------------------------------------------------------------
// control signals of the device
// ----------------------------------------------------------------
`define TB_N_CTRL       8
`define TB_SEL_W        3
`define TB_CTRL_OUT     8'h0f

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CLKCTL      8'h00
`define REG_CLKSTAT     8'h04
`define REG_ROUTE0      8'h08
`define REG_STRIDE      8'h04
`define CLKCTL_EXT_BIT  0
`define CLKCTL_DRV_BIT  1
`define STAT_EXT_BIT    0
`define STAT_DRV_BIT    1
`define STAT_ALIVE_BIT  2
`define ROUTE_EN_BIT    0
`define ROUTE_DIR_BIT   1
`define ROUTE_LVL_BIT   2
`define ROUTE_SEL_LSB   4
`define RST_EXT         1'h0
`define RST_DRV         1'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TB_CLK_HZ       200000000
`define TB_OSC_HZ       20000000
`define TB_DIV_HALF     (`TB_CLK_HZ / (2 * `TB_OSC_HZ))
`define TB_ALIVE_CYC    16'h0040

`endif

// ===== inc/trig_bus_pkg.sv
// types shared by both ends of the trigger bus
`include "trig_bus_cfg.svh"

package trig_bus_pkg;
    typedef logic [`TB_ADDR_W-1:0] addr_t;
    typedef logic [`TB_DATA_W-1:0] data_t;
    typedef logic [`TB_NLINES-1:0] lines_t;
    typedef logic [`TB_N_CTRL-1:0] ctrl_t;
    typedef enum logic [1:0] {
        SRC_INT = 2'b01,
        SRC_EXT = 2'b10
    } tb_src_t;
endpackage : trig_bus_pkg

// ===== inc/trig_bus_if.sv
// shared trigger bus: seven trigger lines plus the system clock line
`include "trig_bus_cfg.svh"

interface trig_bus_if (
    input wire logic bench_clk
);
    trig_bus_pkg::lines_t dev_trig_o;
    trig_bus_pkg::lines_t dev_trig_oe;
    trig_bus_pkg::lines_t far_trig_o;
    trig_bus_pkg::lines_t far_trig_oe;
    trig_bus_pkg::lines_t trig;
    logic                 dev_clk_o;
    logic                 dev_clk_oe;
    logic                 far_clk_o;
    logic                 far_clk_oe;
    logic                 sysclk;

    // undriven lines read low, as the bias pulls them down
    assign trig   = (dev_trig_o & dev_trig_oe) | (far_trig_o & far_trig_oe);
    // the clock rides as line 7 of the backplane connector
    assign sysclk = dev_clk_oe ? dev_clk_o : (far_clk_oe ? far_clk_o : bench_clk);

    modport dev (
        output dev_trig_o,
        output dev_trig_oe,
        output dev_clk_o,
        output dev_clk_oe,
        input  trig,
        input  sysclk
    );

    modport far (
        output far_trig_o,
        output far_trig_oe,
        output far_clk_o,
        output far_clk_oe,
        input  trig,
        input  sysclk
    );
endinterface : trig_bus_if

// ===== rtl/trig_far_end.sv
// far end: another board sharing the trigger lines and the clock line
`include "trig_bus_cfg.svh"

module trig_far_end (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // bus side
    trig_bus_if.far                   bus,
    // user side
    input  wire trig_bus_pkg::lines_t drive_en,
    input  wire trig_bus_pkg::lines_t drive_val,
    input  wire logic                 clk_drive,
    output trig_bus_pkg::lines_t      seen
);
    import trig_bus_pkg::*;

    localparam logic [7:0] DIV_LAST = 8'(`TB_DIV_HALF - 1);

    lines_t     drv_o_q;
    lines_t     drv_oe_q;
    lines_t     line_s1_q;
    lines_t     line_s2_q;
    logic [7:0] div_q;
    logic       osc_q;
    logic       clk_oe_q;

    // ----------------------------------------------------------------
    // trigger lines
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            drv_o_q  <= '0;
            drv_oe_q <= '0;
        end
        else
        begin
            drv_o_q  <= drive_val & drive_en;
            drv_oe_q <= drive_en;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            line_s1_q <= '0;
            line_s2_q <= '0;
        end
        else
        begin
            line_s1_q <= bus.trig;
            line_s2_q <= line_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // 20 MHz timebase offered on the clock line
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q    <= 8'h00;
            osc_q    <= 1'h0;
            clk_oe_q <= 1'h0;
        end
        else
        begin
            div_q    <= (div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
            osc_q    <= (div_q == DIV_LAST) ? ~osc_q : osc_q;
            clk_oe_q <= clk_drive;
        end
    end

    assign bus.far_trig_o  = drv_o_q;
    assign bus.far_trig_oe = drv_oe_q;
    assign bus.far_clk_o   = osc_q;
    assign bus.far_clk_oe  = clk_oe_q;
    assign seen            = line_s2_q;
endmodule : trig_far_end

// ===== rtl/trig_route_dev.sv
// device end: routes control signals and the timebase to the trigger bus
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`include "trig_bus_cfg.svh"

module trig_route_dev #(
    parameter int                       N_CTRL       = `TB_N_CTRL,
    parameter int                       SEL_W        = `TB_SEL_W,
    parameter logic [`TB_N_CTRL-1:0]    CTRL_IS_OUT  = `TB_CTRL_OUT,
    parameter logic [15:0]              ALIVE_CYCLES = `TB_ALIVE_CYC
) (
    // clocks and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 link_clk,
    // bus side
    trig_bus_if.dev                   bus,
    // register port
    input  wire trig_bus_pkg::addr_t  addr,
    input  wire trig_bus_pkg::data_t  wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output trig_bus_pkg::data_t       rdata,
    // control signals of the device core
    input  wire trig_bus_pkg::ctrl_t  ctrl_out,
    output trig_bus_pkg::ctrl_t       ctrl_in,
    // clock tree select: high picks the bus clock
    output logic                      tb_ext
);
    import trig_bus_pkg::*;

    localparam int         NL       = `TB_NLINES;
    localparam logic [7:0] DIV_LAST = 8'(`TB_DIV_HALF - 1);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_route(addr_t a, int i);
        return a == addr_t'(`REG_ROUTE0 + i * `REG_STRIDE);
    endfunction : is_route

    function automatic logic drives(logic en, logic [SEL_W-1:0] sel);
        return en & CTRL_IS_OUT[sel];
    endfunction : drives

    // ----------------------------------------------------------------
    // registers, system clock side
    // ----------------------------------------------------------------
    tb_src_t          src_q;
    logic             drv_en_q;
    logic [NL-1:0]    route_en_q;
    logic [SEL_W-1:0] route_sel_q [NL];
    logic             dirty_q;
    data_t            rdata_q;
    ctrl_t            ctrl_in_q;
    logic             tb_ext_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            src_q    <= SRC_INT;
            drv_en_q <= `RST_DRV;
        end
        else if (wr && addr == `REG_CLKCTL)
        begin
            src_q    <= wdata[`CLKCTL_EXT_BIT] ? SRC_EXT : SRC_INT;
            drv_en_q <= wdata[`CLKCTL_DRV_BIT];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NL; gi++)
        begin : g_route
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    route_en_q[gi]  <= 1'h0;
                    route_sel_q[gi] <= '0;
                end
                else if (wr && is_route(addr, gi))
                begin
                    route_en_q[gi]  <= wdata[`ROUTE_EN_BIT];
                    route_sel_q[gi] <= wdata[`ROUTE_SEL_LSB +: SEL_W];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // route word handed to the link domain by toggle handshake
    // ----------------------------------------------------------------
    logic             req_q;
    logic             req_s1_q;
    logic             req_s2_q;
    logic             req_s3_q;
    logic             ack_s1_q;
    logic             ack_s2_q;
    logic             launch;
    logic [NL-1:0]    xfer_drv_q;
    logic [SEL_W-1:0] xfer_sel_q [NL];
    logic             route_wr;

    always_comb
    begin
        route_wr = 1'h0;
        for (int i = 0; i < NL; i++)
        begin
            route_wr = route_wr | (wr & is_route(addr, i));
        end
    end

    // the word stays frozen while a request is in flight
    assign launch = dirty_q && (req_q == ack_s2_q);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dirty_q <= 1'h0;
        end
        else
        begin
            // a write in the launch cycle keeps the word pending
            dirty_q <= route_wr | (dirty_q & ~launch);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_q      <= 1'h0;
            xfer_drv_q <= '0;
            for (int i = 0; i < NL; i++)
            begin
                xfer_sel_q[i] <= '0;
            end
        end
        else if (launch)
        begin
            req_q <= ~req_q;
            for (int i = 0; i < NL; i++)
            begin
                xfer_drv_q[i] <= drives(route_en_q[i], route_sel_q[i]);
                xfer_sel_q[i] <= route_sel_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_s1_q <= 1'h0;
            ack_s2_q <= 1'h0;
        end
        else
        begin
            ack_s1_q <= req_s3_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // link domain: drivers of the trigger lines
    // ----------------------------------------------------------------
    logic [NL-1:0]    sh_drv_q;
    logic [SEL_W-1:0] sh_sel_q [NL];
    ctrl_t            cout_s1_q;
    ctrl_t            cout_s2_q;
    lines_t           trig_o_q;
    lines_t           trig_oe_q;

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_s1_q  <= 1'h0;
            req_s2_q  <= 1'h0;
            req_s3_q  <= 1'h0;
            cout_s1_q <= '0;
            cout_s2_q <= '0;
        end
        else
        begin
            req_s1_q  <= req_q;
            req_s2_q  <= req_s1_q;
            req_s3_q  <= req_s2_q;
            cout_s1_q <= ctrl_out;
            cout_s2_q <= cout_s1_q;
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sh_drv_q <= '0;
            for (int i = 0; i < NL; i++)
            begin
                sh_sel_q[i] <= '0;
            end
        end
        else if (req_s2_q != req_s3_q)
        begin
            sh_drv_q <= xfer_drv_q;
            for (int i = 0; i < NL; i++)
            begin
                sh_sel_q[i] <= xfer_sel_q[i];
            end
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_o_q  <= '0;
            trig_oe_q <= '0;
        end
        else
        begin
            for (int i = 0; i < NL; i++)
            begin
                trig_o_q[i] <= sh_drv_q[i] & cout_s2_q[sh_sel_q[i]];
            end
            trig_oe_q <= sh_drv_q;
        end
    end

    // ----------------------------------------------------------------
    // receive path into the core
    // ----------------------------------------------------------------
    lines_t line_s1_q;
    lines_t line_s2_q;
    ctrl_t  ctrl_in_d;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            line_s1_q <= '0;
            line_s2_q <= '0;
        end
        else
        begin
            line_s1_q <= bus.trig;
            line_s2_q <= line_s1_q;
        end
    end

    // a received signal is the OR of every enabled line routed to it
    always_comb
    begin
        ctrl_in_d = '0;
        for (int s = 0; s < N_CTRL; s++)
        begin
            for (int i = 0; i < NL; i++)
            begin
                if (route_en_q[i] && !CTRL_IS_OUT[s] && route_sel_q[i] == SEL_W'(s))
                begin
                    ctrl_in_d[s] = ctrl_in_d[s] | line_s2_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_in_q <= '0;
        end
        else
        begin
            ctrl_in_q <= ctrl_in_d;
        end
    end

    // ----------------------------------------------------------------
    // timebase: internal divider and bus clock watch
    // ----------------------------------------------------------------
    logic [7:0]  div_q;
    logic        osc_q;
    logic        clk_oe_q;
    logic        bclk_s1_q;
    logic        bclk_s2_q;
    logic        bclk_s3_q;
    logic [15:0] alive_cnt_q;
    logic        alive_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q    <= 8'h00;
            osc_q    <= 1'h0;
            clk_oe_q <= 1'h0;
            tb_ext_q <= `RST_EXT;
        end
        else
        begin
            div_q    <= (div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
            osc_q    <= (div_q == DIV_LAST) ? ~osc_q : osc_q;
            clk_oe_q <= (src_q == SRC_INT) && drv_en_q;
            tb_ext_q <= (src_q == SRC_EXT);
        end
    end

    // a bus clock is called alive if it rose within the window
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bclk_s1_q   <= 1'h0;
            bclk_s2_q   <= 1'h0;
            bclk_s3_q   <= 1'h0;
            alive_cnt_q <= 16'h0000;
            alive_q     <= 1'h0;
        end
        else
        begin
            bclk_s1_q   <= bus.sysclk;
            bclk_s2_q   <= bclk_s1_q;
            bclk_s3_q   <= bclk_s2_q;
            if (bclk_s2_q && !bclk_s3_q)
                alive_cnt_q <= 16'h0000;
            else if (alive_cnt_q != ALIVE_CYCLES)
                alive_cnt_q <= alive_cnt_q + 16'h0001;
            alive_q     <= (alive_cnt_q != ALIVE_CYCLES);
        end
    end

    // ----------------------------------------------------------------
    // register read, data one cycle after the strobe
    // ----------------------------------------------------------------
    data_t rd_val;

    always_comb
    begin
        rd_val = '0;
        if (addr == `REG_CLKCTL)
        begin
            rd_val[`CLKCTL_EXT_BIT] = (src_q == SRC_EXT);
            rd_val[`CLKCTL_DRV_BIT] = drv_en_q;
        end
        else if (addr == `REG_CLKSTAT)
        begin
            rd_val[`STAT_EXT_BIT]   = tb_ext_q;
            rd_val[`STAT_DRV_BIT]   = clk_oe_q;
            rd_val[`STAT_ALIVE_BIT] = alive_q;
        end
        for (int i = 0; i < NL; i++)
        begin
            if (is_route(addr, i))
            begin
                rd_val[`ROUTE_EN_BIT]                  = route_en_q[i];
                rd_val[`ROUTE_DIR_BIT]                 = drives(route_en_q[i], route_sel_q[i]);
                rd_val[`ROUTE_LVL_BIT]                 = line_s2_q[i];
                rd_val[`ROUTE_SEL_LSB +: SEL_W]        = route_sel_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= '0;
        else
            rdata_q <= rd ? rd_val : '0;
    end

    assign rdata           = rdata_q;
    assign ctrl_in         = ctrl_in_q;
    assign tb_ext          = tb_ext_q;
    assign bus.dev_trig_o  = trig_o_q;
    assign bus.dev_trig_oe = trig_oe_q;
    assign bus.dev_clk_o   = osc_q;
    assign bus.dev_clk_oe  = clk_oe_q;
endmodule : trig_route_dev

// ===== dv/trig_route_checker.sv
// assertions on the clock select and the clock line of the trigger bus
`include "trig_bus_cfg.svh"

module trig_route_checker (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 reset_n,
    // bus signals
    input wire trig_bus_pkg::lines_t dev_trig_oe,
    input wire logic                 dev_clk_o,
    input wire logic                 dev_clk_oe,
    // register port and clock select
    input wire trig_bus_pkg::addr_t  addr,
    input wire trig_bus_pkg::data_t  wdata,
    input wire logic                 wr,
    input wire logic                 tb_ext
);
    timeunit 1ns;
    timeprecision 1ps;
    import trig_bus_pkg::*;

    logic ctl_wr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    assign ctl_wr = wr && (addr == `REG_CLKCTL);

    // ----------------------------------------------------------------
    // oscillator steps
    // ----------------------------------------------------------------
    sequence osc_edge;
        $changed(dev_clk_o);
    endsequence

    // five clk cycles per half period gives 20 MHz at 200 MHz
    sequence osc_hold;
        $stable(dev_clk_o)[*4] ##1 $changed(dev_clk_o);
    endsequence

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_reset_idle: assert property ($rose(reset_n) |-> dev_trig_oe == '0 && !dev_clk_oe && !tb_ext)
        else $error("drivers or clock select active right after reset");
    a_osc_half: assert property (osc_edge |=> osc_hold)
        else $error("oscillator half period is not five cycles");
    a_osc_alive: assert property (1'b1 |-> ##[1:5] $changed(dev_clk_o))
        else $error("oscillator stopped");
    // select register then output flop: the write shows two edges later
    a_ext_set: assert property (ctl_wr && wdata[`CLKCTL_EXT_BIT] |-> ##2 tb_ext)
        else $error("bus clock select not taken");
    a_int_set: assert property (ctl_wr && !wdata[`CLKCTL_EXT_BIT] |-> ##2 !tb_ext)
        else $error("internal clock select not taken");
    a_drive_on: assert property (ctl_wr && wdata[1:0] == 2'b10 |-> ##2 dev_clk_oe)
        else $error("internal timebase not driven onto clock line");
    a_ext_no_drive: assert property (tb_ext |-> !dev_clk_oe)
        else $error("clock line driven while using the bus clock");
    a_sel_hold: assert property (!ctl_wr && !$past(ctl_wr) |=> $stable(tb_ext) && $stable(dev_clk_oe))
        else $error("clock selection changed without a write");
endmodule : trig_route_checker

// ===== dv/trig_bus_clock_routing_tb.sv
// self-checking bench: device end and far end joined on the trigger bus
`include "trig_bus_cfg.svh"

module trig_bus_clock_routing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import trig_bus_pkg::*;

    logic   clk;
    logic   bench_clk;
    logic   reset_n;
    addr_t  addr;
    data_t  wdata;
    logic   wr;
    logic   rd;
    data_t  rdata;
    ctrl_t  ctrl_out;
    ctrl_t  ctrl_in;
    logic   tb_ext;
    lines_t drive_en;
    lines_t drive_val;
    logic   clk_drive;
    lines_t seen;
    int     num_errors;
    int     comparisons;
    int     cycles;
    int     n;

    trig_bus_if bus (.bench_clk(bench_clk));

    trig_route_dev trig_route_dev_inst (
        .clk(clk), .reset_n(reset_n), .link_clk(bus.sysclk), .bus(bus.dev),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ctrl_out(ctrl_out), .ctrl_in(ctrl_in), .tb_ext(tb_ext)
    );

    trig_far_end trig_far_end_inst (
        .clk(clk), .reset_n(reset_n), .bus(bus.far), .drive_en(drive_en),
        .drive_val(drive_val), .clk_drive(clk_drive), .seen(seen)
    );

    trig_route_checker trig_route_checker_inst (
        .clk(clk), .reset_n(reset_n), .dev_trig_oe(bus.dev_trig_oe),
        .dev_clk_o(bus.dev_clk_o), .dev_clk_oe(bus.dev_clk_oe), .addr(addr),
        .wdata(wdata), .wr(wr), .tb_ext(tb_ext)
    );

    // ----------------------------------------------------------------
    // clocks and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // odd offset keeps link edges clear of system clock edges
    initial
    begin
        bench_clk = 1'b0;
        #17;
        forever #62.5 bench_clk = ~bench_clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------------
    task automatic reg_wr(input addr_t a, input data_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr

    task automatic check_val(input string what, input data_t exp, input data_t got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic reg_chk(input addr_t a, input data_t mask, input data_t exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check_val($sformatf("register %h", a), exp, rdata & mask);
    endtask : reg_chk

    // counts clock line changes over 100 system cycles
    task automatic count_toggles(output int cnt);
        logic last;
        cnt = 0;
        // let the clock line settle on its new source first
        repeat (4) @(negedge clk);
        last = bus.sysclk;
        repeat (100)
        begin
            @(negedge clk);
            if (bus.sysclk !== last)
                cnt++;
            last = bus.sysclk;
        end
    endtask : count_toggles

    // routes line i to signal (i+k)%8, far end drives the received lines
    task automatic route_pass(input int k, input ctrl_t co, input lines_t fv);
        lines_t exp_oe;
        lines_t exp_trig;
        lines_t fen;
        ctrl_t  exp_in;
        int     s;
        int     t;
        exp_oe   = '0;
        exp_trig = '0;
        fen      = '0;
        exp_in   = '0;
        @(posedge clk);
        drive_en <= '0;
        ctrl_out <= co;
        for (int i = 0; i < 7; i++)
        begin
            s = (i + k) % 8;
            reg_wr(addr_t'(`REG_ROUTE0 + i * `REG_STRIDE), data_t'((s << `ROUTE_SEL_LSB) | 1));
            if (`TB_CTRL_OUT & (1 << s))
            begin
                exp_oe[i]   = 1'b1;
                exp_trig[i] = co[s];
            end
            else
            begin
                fen[i]      = 1'b1;
                exp_trig[i] = fv[i];
                if (fv[i])
                    exp_in[s] = 1'b1;
            end
        end
        drive_en  <= fen;
        drive_val <= fv;
        t = 0;
        while ((bus.dev_trig_oe !== exp_oe || bus.trig !== exp_trig || ctrl_in !== exp_in
                || seen !== exp_trig) && t < 800)
        begin
            @(negedge clk);
            t++;
        end
        check_val("line drive enables", data_t'(exp_oe), data_t'(bus.dev_trig_oe));
        check_val("line levels", data_t'(exp_trig), data_t'(bus.trig));
        check_val("received signals", data_t'(exp_in), data_t'(ctrl_in));
        check_val("far end view", data_t'(exp_trig), data_t'(seen));
        reg_chk(`REG_ROUTE0, 32'h77,
                data_t'(((k % 8) << 4) | 1 | (exp_oe[0] << 1) | (exp_trig[0] << 2)));
    endtask : route_pass

    task automatic final_report;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        num_errors  = 0;
        comparisons = 0;
        cycles      = 0;
        reset_n     = 1'b0;
        addr        = '0;
        wdata       = '0;
        wr          = 1'b0;
        rd          = 1'b0;
        ctrl_out    = '0;
        drive_en    = '0;
        drive_val   = '0;
        clk_drive   = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check_val("clock select", 32'h0, data_t'(tb_ext));
        reg_chk(`REG_CLKCTL, 32'h3, 32'h0);
        reg_chk(`REG_CLKSTAT, 32'h3, 32'h0);
        reg_chk(8'h40, 32'hffffffff, 32'h0);
        // internal timebase onto the clock line
        reg_wr(`REG_CLKCTL, 32'h2);
        count_toggles(n);
        check_val("internal clock toggles", 32'd20, data_t'(n));
        reg_chk(`REG_CLKSTAT, 32'h7, 32'h6);
        // bus clock taken from the far end; the drive bit must not win
        @(posedge clk);
        clk_drive <= 1'b1;
        reg_wr(`REG_CLKCTL, 32'h3);
        count_toggles(n);
        check_val("far clock toggles", 32'd20, data_t'(n));
        check_val("clock select", 32'h1, data_t'(tb_ext));
        reg_chk(`REG_CLKSTAT, 32'h7, 32'h5);
        // nobody drives: the clock line carries the bench clock
        @(posedge clk);
        clk_drive <= 1'b0;
        reg_wr(`REG_CLKCTL, 32'h1);
        count_toggles(n);
        check_val("bench clock toggles", 32'd8, data_t'(n));
        reg_wr(`REG_CLKCTL, 32'h0);
        repeat (2) @(negedge clk);
        check_val("clock select", 32'h0, data_t'(tb_ext));
        // routing in two passes covers all eight signals
        route_pass(0, 8'h05, 7'h55);
        route_pass(5, 8'h0a, 7'h2a);
        // unrouted lines release their drivers
        @(posedge clk);
        drive_en <= '0;
        for (int i = 0; i < 7; i++)
            reg_wr(addr_t'(`REG_ROUTE0 + i * `REG_STRIDE), 32'h0);
        n = 0;
        while (bus.dev_trig_oe !== '0 && n < 800)
        begin
            @(negedge clk);
            n++;
        end
        check_val("unrouted enables", 32'h0, data_t'(bus.dev_trig_oe));
        final_report();
    end
endmodule : trig_bus_clock_routing_tb
